// [bench/prs_ref_model.sv]
// Purpose: two reference sources facing prs_ref_switch
// Assumes: references change only on clk rising edges
// Notes:   a stopped source is held low, never left at its last level
`timescale 1ns/1ns
`default_nettype none
module prs_ref_model #(
    parameter int HALF = 5
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic runA,
    input  wire logic runB,
    output logic      refA,
    output logic      refB
);
    logic [7:0] cnt;
    // Same rate on both inputs, so automatic sensing stays valid; B lags A
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cnt  <= 8'h00;
            refA <= 1'b0;
            refB <= 1'b0;
        end
        else
        begin
            cnt  <= (cnt == 8'(HALF - 1)) ? 8'h00 : cnt + 8'h01;
            refA <= runA ? refA ^ (cnt == 8'h00) : 1'b0;
            refB <= runB ? refB ^ (cnt == 8'h02) : 1'b0;
        end
    end
endmodule
`default_nettype wire

// [bench/prs_ref_switch_checker.sv]
// Purpose: port assertions for prs_ref_switch
// Assumes: one clock, synchronous active-high rst
// Notes:   bound into every prs_ref_switch instance
`timescale 1ns/1ns
`default_nettype none
module prs_ref_switch_checker (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        ref_clk_a,
    input wire logic        ref_clk_b,
    input wire logic        switchRequest,
    input wire logic        pllLocked,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        refClkOut,
    input wire logic        activeRef,
    input wire logic        ref_a_bad_flag,
    input wire logic        ref_b_bad_flag,
    input wire logic        switchCond,
    input wire logic        gatedLock
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    property p_apb_answer;
        s_setup |=> s_answer;
    endproperty
    property p_err_zero;
        pslverr |-> pready && prdata == 32'h0000_0000;
    endproperty
    property p_ctrl_mapped;
        pready && paddr == 8'h00 |-> !pslverr;
    endproperty
    property p_reset_state;
        $fell(rst) |-> !activeRef && !ref_a_bad_flag && !ref_b_bad_flag && !pready;
    endproperty
    property p_cond_low;
        ref_a_bad_flag || ref_b_bad_flag |-> !switchCond;
    endproperty
    property p_bad_a_edge;
        $rose(ref_a_bad_flag) |-> $past(ref_clk_a, 1) == $past(ref_clk_a, 2);
    endproperty
    property p_ref_out;
        refClkOut |-> $past(ref_clk_a) || $past(ref_clk_b);
    endproperty
    property p_idle_ready;
        !psel |=> !pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("ready not one cycle after setup");
    a_err_zero: assert property (p_err_zero) else $error("error response without ready or zero data");
    a_ctrl_mapped: assert property (p_ctrl_mapped) else $error("error on mapped control word");
    a_reset_state: assert property (p_reset_state) else $error("state not cleared by reset");
    a_cond_low: assert property (p_cond_low) else $error("switch condition high with bad input");
    a_bad_a_edge: assert property (p_bad_a_edge) else $error("input A flagged while toggling");
    a_ref_out: assert property (p_ref_out) else $error("reference output high with no source high");
    a_idle_ready: assert property (p_idle_ready) else $error("ready without a transfer");
endmodule
bind prs_ref_switch prs_ref_switch_checker chk_i (.clk(clk), .rst(rst), .ref_clk_a(ref_clk_a),
    .ref_clk_b(ref_clk_b), .switchRequest(switchRequest), .pllLocked(pllLocked), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .refClkOut(refClkOut), .activeRef(activeRef),
    .ref_a_bad_flag(ref_a_bad_flag), .ref_b_bad_flag(ref_b_bad_flag), .switchCond(switchCond),
    .gatedLock(gatedLock));
`default_nettype wire

// [bench/prs_ref_switch_tb_top.sv]
// Purpose: self-checking bench for prs_ref_switch
// Assumes: 50 MHz clk, APB master held until pready
// Notes:   one idle cycle between transfers keeps each driver edge single
`timescale 1ns/1ns
`default_nettype none
module prs_ref_switch_tb_top;
    logic        clk, rst, refA, refB, runA, runB, switchRequest, pllLocked;
    logic        psel, penable, pwrite, pready, pslverr, refClkOut, activeRef, er, pa;
    logic        badA, badB, switchCond, gatedLock;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    int          err_total, checked, cyc;
    prs_ref_model mdl (.clk(clk), .rst(rst), .runA(runA), .runB(runB), .refA(refA), .refB(refB));
    prs_ref_switch uut (.clk(clk), .rst(rst), .ref_clk_a(refA), .ref_clk_b(refB), .switchRequest(switchRequest),
        .pllLocked(pllLocked), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hf), .pready(pready), .prdata(prdata), .pslverr(pslverr), .refClkOut(refClkOut),
        .activeRef(activeRef), .ref_a_bad_flag(badA), .ref_b_bad_flag(badB), .switchCond(switchCond),
        .gatedLock(gatedLock));
    task end_sim;
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task waitRef(input logic v, input int n);
        repeat (n) if (activeRef !== v) @(posedge clk);
        chk({31'h0, activeRef}, {31'h0, v}, "active reference");
    endtask
    task t_reset;
        apb(1'b0, prs_pkg::OFF_CTRL, 32'h0);
        chk(rd, prs_pkg::CTRL_RESET, "control reset");
        apb(1'b0, prs_pkg::OFF_LOCK_TERM, 32'h0);
        chk(rd, {12'h000, prs_pkg::LOCK_TERM_RST}, "lock term reset");
        apb(1'b0, prs_pkg::OFF_STATUS, 32'h0);
        chk({28'h0, rd[3:0]}, 32'h0, "status reset");
        apb(1'b0, 8'h0c, 32'h0);
        chk(er, 1'b1, "unmapped error");
        chk(rd, 32'h0, "unmapped read");
        repeat (20)
        begin
            pa = refA;
            @(posedge clk);
            chk(refClkOut, pa, "reference output");
        end
        $display("reset test done");
    endtask
    task t_loss;
        runA <= 1'b0;
        repeat (200) if (badA !== 1'b1) @(posedge clk);
        chk({badA, badB}, 2'b10, "bad flags on loss");
        chk(switchCond, 1'b0, "switch condition on loss");
        waitRef(1'b1, 300);
        runA <= 1'b1;
        repeat (200) @(posedge clk);
        chk(activeRef, 1'b1, "no return to A");
        apb(1'b1, prs_pkg::OFF_STATUS, 32'h1);
        chk(badA, 1'b0, "flag cleared");
        $display("loss test done");
    endtask
    task t_manual;
        apb(1'b1, prs_pkg::OFF_CTRL, 32'h16);
        waitRef(1'b0, 300);
        runB <= 1'b0;
        switchRequest <= 1'b1;
        repeat (200) @(posedge clk);
        chk(activeRef, 1'b0, "waits for dead B");
        runB <= 1'b1;
        waitRef(1'b1, 300);
        switchRequest <= 1'b0;
        waitRef(1'b0, 300);
        apb(1'b1, prs_pkg::OFF_STATUS, 32'h3);
        $display("manual test done");
    endtask
    task t_override;
        apb(1'b1, prs_pkg::OFF_CTRL, 32'h11f);
        switchRequest <= 1'b1;
        waitRef(1'b1, 300);
        chk({badA, badB, switchCond}, 3'b001, "override flags");
        switchRequest <= 1'b0;
        repeat (200) @(posedge clk);
        chk(activeRef, 1'b1, "fall keeps B");
        switchRequest <= 1'b1;
        waitRef(1'b0, 300);
        switchRequest <= 1'b0;
        chk(gatedLock, 1'b1, "gated lock");
        pllLocked <= 1'b0;
        waitRef(1'b1, 300);
        pllLocked <= 1'b1;
        $display("override test done");
    endtask
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            end_sim;
        end
    end
    initial
    begin
        {rst, runA, runB, pllLocked} = 4'hf;
        {switchRequest, psel, penable, pwrite, paddr, pwdata} = '0;
        {err_total, checked, cyc} = '0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_loss;
        t_manual;
        t_override;
        end_sim;
    end
endmodule
`default_nettype wire

// [hw/prs_pkg.sv]
// Purpose: constants for the PLL reference switchover block
// Assumes: 32-bit APB, 50 MHz system clock
// Notes:   offsets are byte addresses
// Notes on behaviour
// - Select one of two references; switch on loss or on request.
// - Loss switching only moves from input A to input B.
// - Input A stuck low about two cycles raises its bad flag.
// - Edge counters clear together at pairs (1,1),(1,2),(2,1),(2,2).
// - A counter reaching three marks the other input bad.
// - Configurable destination edge count before switchover may proceed.
// - Rising request starts sequence; output gated on current falling edge.
// - Override changes select on destination falling edge, with designation.
// - Override: switch condition follows the request; active indicator toggles on each request rise.
// - Only request rising edges switch; each new rise repeats it.
// - Switchover completes only once the destination toggles.
// - Lock enable stays off until gated lock count reaches terminal.
// - Gated lock high with ungated lock low starts an override switch.
// - Manual mode: request low selects A, high selects B.
// - Manual: gate on current falling edge, switch on destination rising edge.
// - Manual: falling request runs the same sequence back to A.
// - Full variant has automatic and manual; reduced has manual only.
// - Bad flags and switch condition are exported to user logic.
// - Optional five-bit delay postpones the reference change.
// - Active indicator is 0 for input A and 1 for input B.
package prs_pkg;

    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;

    localparam logic [7:0]  OFF_CTRL      = 8'h00;
    localparam logic [7:0]  OFF_STATUS    = 8'h04;
    localparam logic [7:0]  OFF_LOCK_TERM = 8'h08;

    // Control field positions
    localparam int          C_AUTO        = 0;
    localparam int          C_FULL        = 1;
    localparam int          C_LOCK_EN     = 2;
    localparam int          C_DELAY_EN    = 3;
    localparam int          C_HOLD_LSB    = 4;
    localparam int          HOLD_W        = 4;
    localparam int          C_DELAY_LSB   = 8;
    localparam int          DELAY_W       = 5;

    localparam logic [31:0] CTRL_RESET    = 32'h0000_0017;

    // Status field positions
    localparam int          S_BAD_A       = 0;
    localparam int          S_BAD_B       = 1;
    localparam int          S_COND        = 2;
    localparam int          S_ACTIVE      = 3;
    localparam int          S_GLOCK       = 4;
    localparam int          S_BUSY        = 5;

    localparam int          LOCK_W        = 20;
    localparam logic [19:0] LOCK_TERM_RST = 20'h00010;

    localparam int          EDGE_W        = 2;
    localparam logic [1:0]  EDGE_ZERO     = 2'h0;
    localparam logic [1:0]  EDGE_ONE      = 2'h1;
    localparam logic [1:0]  EDGE_MISS     = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_GATE,
        ST_WAIT_DEST,
        ST_DELAY,
        ST_SWITCH
    } prs_state_e;

endpackage

// [hw/prs_ref_switch.sv]
// Purpose: reference clock switchover in front of a PLL, APB slave
// Assumes: references are sampled as synchronous inputs of clk
// Notes:   refClkOut is the gated, selected reference
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ns
`default_nettype none

module prs_ref_switch (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ref_clk_a,
    input  wire logic        ref_clk_b,
    input  wire logic        switchRequest,
    input  wire logic        pllLocked,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    output logic             refClkOut,
    output logic             activeRef,
    output logic             ref_a_bad_flag,
    output logic             ref_b_bad_flag,
    output logic             switchCond,
    output logic             gatedLock
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic edgeOf(input logic cur, input logic prev, input logic rising);
        edgeOf = rising ? (cur & ~prev) : (~cur & prev);
    endfunction

    function automatic logic [31:0] laneMask(input logic [3:0] strb);
        laneMask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic                   autoMode;
    logic                   fullVariant;
    logic                   lockSwEn;
    logic                   delayEn;
    logic [3:0]             holdCount;
    logic [4:0]             delayCount;
    logic [19:0]            lockTerm;
    logic                   prevA;
    logic                   prevB;
    logic                   prevReq;
    logic [1:0]             edge_count_a;
    logic [1:0]             edge_count_b;
    prs_pkg::prs_state_e    state;
    logic                   destSel;
    logic                   manualSeq;
    logic                   gateOn;
    logic [3:0]             holdCnt;
    logic [4:0]             delayCnt;
    logic [19:0]            lockCnt;

    logic                   next_autoMode;
    logic                   next_fullVariant;
    logic                   next_lockSwEn;
    logic                   next_delayEn;
    logic [3:0]             next_holdCount;
    logic [4:0]             next_delayCount;
    logic [19:0]            next_lockTerm;
    logic                   next_pready;
    logic [31:0]            next_prdata;
    logic                   next_pslverr;
    logic [1:0]             next_edge_count_a;
    logic [1:0]             next_edge_count_b;
    logic                   next_badA;
    logic                   next_badB;
    logic                   next_switchCond;
    prs_pkg::prs_state_e    next_state;
    logic                   next_destSel;
    logic                   next_manualSeq;
    logic                   next_gateOn;
    logic                   next_activeRef;
    logic [3:0]             next_holdCnt;
    logic [4:0]             next_delayCnt;
    logic                   next_refClkOut;
    logic [19:0]            next_lockCnt;
    logic                   next_gatedLock;

    logic                   wrEn;
    logic                   rdSetup;
    logic [31:0]            ctrlWord;
    logic [31:0]            ctrlNew;
    logic [31:0]            wrMask;
    logic [31:0]            statusWord;
    logic                   clrBadA;
    logic                   clrBadB;
    logic                   autoOk;
    logic                   riseA;
    logic                   riseB;
    logic                   reqRise;
    logic                   curFall;
    logic                   curBad;
    logic                   destRise;
    logic                   destFall;
    logic                   selRise;
    logic                   lockTrig;
    logic                   startLock;
    logic [1:0]             incA;
    logic [1:0]             incB;

    assign autoOk = fullVariant & autoMode;
    assign riseA  = edgeOf(ref_clk_a, prevA, 1'b1);
    assign riseB  = edgeOf(ref_clk_b, prevB, 1'b1);
    assign reqRise = switchRequest & ~prevReq;

    // ------------------------------------------------------------
    // APB slave and configuration
    // ------------------------------------------------------------
    // Zero wait state: pready rises for the access phase of every transfer.
    assign wrEn    = psel & penable & pready & pwrite;
    assign rdSetup = psel & ~penable;
    assign wrMask  = laneMask(pstrb);

    always_comb
    begin
        ctrlWord = '0;
        ctrlWord[prs_pkg::C_AUTO]     = autoMode;
        ctrlWord[prs_pkg::C_FULL]     = fullVariant;
        ctrlWord[prs_pkg::C_LOCK_EN]  = lockSwEn;
        ctrlWord[prs_pkg::C_DELAY_EN] = delayEn;
        ctrlWord[prs_pkg::C_HOLD_LSB +: prs_pkg::HOLD_W]   = holdCount;
        ctrlWord[prs_pkg::C_DELAY_LSB +: prs_pkg::DELAY_W] = delayCount;
        statusWord = '0;
        statusWord[prs_pkg::S_BAD_A]  = ref_a_bad_flag;
        statusWord[prs_pkg::S_BAD_B]  = ref_b_bad_flag;
        statusWord[prs_pkg::S_COND]   = switchCond;
        statusWord[prs_pkg::S_ACTIVE] = activeRef;
        statusWord[prs_pkg::S_GLOCK]  = gatedLock;
        statusWord[prs_pkg::S_BUSY]   = (state != prs_pkg::ST_IDLE);
        ctrlNew = (ctrlWord & ~laneMask(pstrb)) | (pwdata & laneMask(pstrb));
    end

    assign clrBadA = wrEn && paddr == prs_pkg::OFF_STATUS && pstrb[0] && pwdata[prs_pkg::S_BAD_A];
    assign clrBadB = wrEn && paddr == prs_pkg::OFF_STATUS && pstrb[0] && pwdata[prs_pkg::S_BAD_B];

    always_comb
    begin
        next_autoMode    = autoMode;
        next_fullVariant = fullVariant;
        next_lockSwEn    = lockSwEn;
        next_delayEn     = delayEn;
        next_holdCount   = holdCount;
        next_delayCount  = delayCount;
        next_lockTerm    = lockTerm;
        next_pready      = rdSetup;
        next_prdata      = '0;
        next_pslverr     = 1'b0;
        if (rdSetup)
        begin
            case (paddr)
                prs_pkg::OFF_CTRL:      next_prdata = pwrite ? '0 : ctrlWord;
                prs_pkg::OFF_STATUS:    next_prdata = pwrite ? '0 : statusWord;
                prs_pkg::OFF_LOCK_TERM: next_prdata = pwrite ? '0 : {12'h000, lockTerm};
                default:                next_pslverr = 1'b1;
            endcase
        end
        if (wrEn && paddr == prs_pkg::OFF_CTRL)
        begin
            next_autoMode    = ctrlNew[prs_pkg::C_AUTO];
            next_fullVariant = ctrlNew[prs_pkg::C_FULL];
            next_lockSwEn    = ctrlNew[prs_pkg::C_LOCK_EN];
            next_delayEn     = ctrlNew[prs_pkg::C_DELAY_EN];
            next_holdCount   = ctrlNew[prs_pkg::C_HOLD_LSB +: prs_pkg::HOLD_W];
            next_delayCount  = ctrlNew[prs_pkg::C_DELAY_LSB +: prs_pkg::DELAY_W];
        end
        if (wrEn && paddr == prs_pkg::OFF_LOCK_TERM)
        begin
            next_lockTerm = (lockTerm & ~wrMask[19:0]) | (pwdata[19:0] & wrMask[19:0]);
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            autoMode    <= prs_pkg::CTRL_RESET[prs_pkg::C_AUTO];
            fullVariant <= prs_pkg::CTRL_RESET[prs_pkg::C_FULL];
            lockSwEn    <= prs_pkg::CTRL_RESET[prs_pkg::C_LOCK_EN];
            delayEn     <= prs_pkg::CTRL_RESET[prs_pkg::C_DELAY_EN];
            holdCount   <= prs_pkg::CTRL_RESET[prs_pkg::C_HOLD_LSB +: prs_pkg::HOLD_W];
            delayCount  <= prs_pkg::CTRL_RESET[prs_pkg::C_DELAY_LSB +: prs_pkg::DELAY_W];
            lockTerm    <= prs_pkg::LOCK_TERM_RST;
            pready      <= 1'b0;
            prdata      <= '0;
            pslverr     <= 1'b0;
        end
        else
        begin
            autoMode    <= next_autoMode;
            fullVariant <= next_fullVariant;
            lockSwEn    <= next_lockSwEn;
            delayEn     <= next_delayEn;
            holdCount   <= next_holdCount;
            delayCount  <= next_delayCount;
            lockTerm    <= next_lockTerm;
            pready      <= next_pready;
            prdata      <= next_prdata;
            pslverr     <= next_pslverr;
        end
    end

    // ------------------------------------------------------------
    // Edge supervision
    // ------------------------------------------------------------
    // Only the full variant supervises; flags stay low in the reduced one.
    always_comb
    begin
        incA = edge_count_a + {1'b0, riseA};
        incB = edge_count_b + {1'b0, riseB};
        next_edge_count_a = incA;
        next_edge_count_b = incB;
        next_badA = ref_a_bad_flag & ~clrBadA;
        next_badB = ref_b_bad_flag & ~clrBadB;
        if (incB == prs_pkg::EDGE_MISS)
        begin
            next_badA = 1'b1;
            next_edge_count_a = prs_pkg::EDGE_ZERO;
            next_edge_count_b = prs_pkg::EDGE_ZERO;
        end
        else if (incA == prs_pkg::EDGE_MISS)
        begin
            next_badB = 1'b1;
            next_edge_count_a = prs_pkg::EDGE_ZERO;
            next_edge_count_b = prs_pkg::EDGE_ZERO;
        end
        else if (incA >= prs_pkg::EDGE_ONE && incB >= prs_pkg::EDGE_ONE)
        begin
            next_edge_count_a = prs_pkg::EDGE_ZERO;
            next_edge_count_b = prs_pkg::EDGE_ZERO;
        end
        if (!fullVariant)
        begin
            next_badA = 1'b0;
            next_badB = 1'b0;
            next_edge_count_a = prs_pkg::EDGE_ZERO;
            next_edge_count_b = prs_pkg::EDGE_ZERO;
        end
        // Low on a detected loss or outside automatic mode, otherwise mirrors the request
        next_switchCond = autoOk & ~(next_badA | next_badB) & switchRequest;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            prevA          <= 1'b0;
            prevB          <= 1'b0;
            prevReq        <= 1'b0;
            edge_count_a   <= prs_pkg::EDGE_ZERO;
            edge_count_b   <= prs_pkg::EDGE_ZERO;
            ref_a_bad_flag <= 1'b0;
            ref_b_bad_flag <= 1'b0;
            switchCond     <= 1'b0;
        end
        else
        begin
            prevA          <= ref_clk_a;
            prevB          <= ref_clk_b;
            prevReq        <= switchRequest;
            edge_count_a   <= next_edge_count_a;
            edge_count_b   <= next_edge_count_b;
            ref_a_bad_flag <= next_badA;
            ref_b_bad_flag <= next_badB;
            switchCond     <= next_switchCond;
        end
    end

    // ------------------------------------------------------------
    // Switchover sequencer
    // ------------------------------------------------------------
    assign curFall  = activeRef ? edgeOf(ref_clk_b, prevB, 1'b0) : edgeOf(ref_clk_a, prevA, 1'b0);
    assign curBad   = activeRef ? ref_b_bad_flag : ref_a_bad_flag;
    assign destRise = destSel ? riseB : riseA;
    assign destFall = destSel ? edgeOf(ref_clk_b, prevB, 1'b0) : edgeOf(ref_clk_a, prevA, 1'b0);
    assign selRise  = activeRef ? riseB : riseA;
    assign lockTrig = autoOk & lockSwEn & gatedLock & ~pllLocked;

    always_comb
    begin
        next_state     = state;
        next_destSel   = destSel;
        next_manualSeq = manualSeq;
        next_gateOn    = gateOn;
        next_activeRef = activeRef;
        next_holdCnt   = holdCnt;
        next_delayCnt  = delayCnt;
        startLock      = 1'b0;
        case (state)
            prs_pkg::ST_IDLE:
            begin
                next_holdCnt  = '0;
                next_delayCnt = delayCount;
                if (!autoOk)
                begin
                    if (switchRequest != activeRef)
                    begin
                        next_destSel   = switchRequest;
                        next_manualSeq = 1'b1;
                        next_state     = prs_pkg::ST_GATE;
                    end
                end
                else if (reqRise || lockTrig)
                begin
                    next_destSel   = ~activeRef;
                    next_manualSeq = 1'b0;
                    startLock      = lockTrig;
                    next_state     = prs_pkg::ST_GATE;
                end
                else if (!activeRef && ref_a_bad_flag && !ref_b_bad_flag)
                begin
                    next_destSel   = 1'b1;
                    next_manualSeq = 1'b0;
                    next_state     = prs_pkg::ST_GATE;
                end
            end
            prs_pkg::ST_GATE:
            begin
                // A dead reference never falls, so gate at once
                if (curFall || curBad)
                begin
                    next_gateOn = 1'b0;
                    next_state  = prs_pkg::ST_WAIT_DEST;
                end
            end
            prs_pkg::ST_WAIT_DEST:
            begin
                if (holdCnt >= holdCount)
                begin
                    next_state = delayEn ? prs_pkg::ST_DELAY : prs_pkg::ST_SWITCH;
                end
                else if (destRise)
                begin
                    next_holdCnt = holdCnt + 4'h1;
                end
            end
            prs_pkg::ST_DELAY:
            begin
                if (delayCnt == '0)
                begin
                    next_state = prs_pkg::ST_SWITCH;
                end
                else if (destRise)
                begin
                    next_delayCnt = delayCnt - 5'h01;
                end
            end
            prs_pkg::ST_SWITCH:
            begin
                if (manualSeq ? destRise : destFall)
                begin
                    next_activeRef = destSel;
                    next_gateOn    = 1'b1;
                    next_state     = prs_pkg::ST_IDLE;
                end
            end
            default:
            begin
                next_state  = prs_pkg::ST_IDLE;
                next_gateOn = 1'b1;
            end
        endcase
        next_refClkOut = gateOn & (activeRef ? ref_clk_b : ref_clk_a);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state     <= prs_pkg::ST_IDLE;
            destSel   <= 1'b0;
            manualSeq <= 1'b0;
            gateOn    <= 1'b1;
            activeRef <= 1'b0;
            holdCnt   <= '0;
            delayCnt  <= '0;
            refClkOut <= 1'b0;
        end
        else
        begin
            state     <= next_state;
            destSel   <= next_destSel;
            manualSeq <= next_manualSeq;
            gateOn    <= next_gateOn;
            activeRef <= next_activeRef;
            holdCnt   <= next_holdCnt;
            delayCnt  <= next_delayCnt;
            refClkOut <= next_refClkOut;
        end
    end

    // ------------------------------------------------------------
    // Gated lock counter
    // ------------------------------------------------------------
    // Gated lock latches at terminal count so a later loss of the
    // ungated lock can still be seen as a switch request.
    always_comb
    begin
        next_lockCnt   = lockCnt;
        next_gatedLock = gatedLock;
        if (startLock)
        begin
            next_lockCnt   = '0;
            next_gatedLock = 1'b0;
        end
        else if (pllLocked && !gatedLock && selRise)
        begin
            if (lockCnt + 20'h00001 >= lockTerm)
            begin
                next_gatedLock = 1'b1;
            end
            else
            begin
                next_lockCnt = lockCnt + 20'h00001;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            lockCnt   <= '0;
            gatedLock <= 1'b0;
        end
        else
        begin
            lockCnt   <= next_lockCnt;
            gatedLock <= next_gatedLock;
        end
    end

endmodule

`default_nettype wire
